// file: hdl/baud_gen_pkg.sv
package baud_gen_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] RCV_STATUS_IDX  = 8'h13;
  localparam logic [7:0] XMT_STATUS_IDX  = 8'h15;
  localparam logic [7:0] BAUD_DIV_IDX    = 8'h17;
  localparam logic [7:0] TIMER_STAT_IDX  = 8'h18;

  // ==========================================================
  // Field positions
  localparam int RCV_ENABLE_BIT    = 7;
  localparam int RCV_NINE_BIT      = 6;
  localparam int RCV_SINGLE_BIT    = 5;
  localparam int RCV_CONT_BIT      = 4;
  localparam int XMT_CLKSRC_BIT    = 7;
  localparam int XMT_NINE_BIT      = 6;
  localparam int XMT_ENABLE_BIT    = 5;
  localparam int XMT_SYNC_BIT      = 4;
  localparam int XMT_SHIFT_EMPTY   = 1;
  localparam int XMT_NINTH_BIT     = 0;

  // Writable masks: unimplemented and status bits read as fixed values
  localparam logic [7:0] RCV_WRITE_MASK = 8'hf0;
  localparam logic [7:0] XMT_WRITE_MASK = 8'hf1;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RCV_STATUS_RST = 8'h00;
  localparam logic [7:0] XMT_STATUS_RST = 8'h00;
  localparam logic [7:0] BAUD_DIV_RST   = 8'h00;

  // ==========================================================
  // Counts
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam int         SYNC_DIVIDE   = 4;
  localparam int         ASYNC_DIVIDE  = 64;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avl_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdData;
    logic [7:0]  rcvStatus;
    logic [7:0]  xmtStatus;
    logic [7:0]  divisor;
    logic [1:0]  prescale;
    logic [7:0]  timer;
    logic [3:0]  oversample;
    logic        rateTick;
  } state_type;

endpackage : baud_gen_pkg

// file: hdl/serial_baud_rate_generator.sv
`timescale 1ns/1ns
// Contract
// - Dedicated 8-bit free-running timer, divisor period
// - Divisor accepts every value 0 to 255
// - Async rate is Fosc over 64(X+1)
// - Sync rate is Fosc over 4(X+1)
// - Tick drives port only async or master
// - Divisor write clears timer immediately
// - Every reset clears divisor to zero
// - Mode bit set selects sync, clear async
// - Clock source set master, clear slave; async mode holds clockMaster low

module serial_baud_rate_generator (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  // Avalon-MM slave
  input  wire baud_gen_pkg::avl_req_type avlReq,
  output logic [31:0]                    readdata,
  output logic                           waitrequest,
  // Serial port side
  output logic                           rateTick,
  output logic                           syncMode,
  output logic                           clockMaster,
  output logic                           portEnable
);

  // ==========================================================
  // State
  baud_gen_pkg::state_type st_r;
  baud_gen_pkg::state_type st_nxt;

  logic       busReq;
  logic       accept;
  logic       wrAccept;
  logic       divWrite;
  logic       baseTick;
  logic       tickActive;

  function automatic logic [31:0] read_mux(input logic [7:0] idx,
                                           input baud_gen_pkg::state_type s);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (idx)
      baud_gen_pkg::RCV_STATUS_IDX: d[7:0] = s.rcvStatus;
      baud_gen_pkg::XMT_STATUS_IDX: begin
        d[7:0] = s.xmtStatus;
        // No shift register here: always reported empty
        d[baud_gen_pkg::XMT_SHIFT_EMPTY] = 1'b1;
      end
      baud_gen_pkg::BAUD_DIV_IDX:   d[7:0] = s.divisor;
      baud_gen_pkg::TIMER_STAT_IDX: d[7:0] = s.timer;
      default:                      d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_mux

  // ==========================================================
  // Bus decode: one wait cycle, answer on the second
  assign busReq      = avlReq.read | avlReq.write;
  assign waitrequest = busReq & ~st_r.ack;
  assign accept      = busReq & st_r.ack;
  assign wrAccept    = accept & avlReq.write & avlReq.byteenable[0]
                       & (avlReq.address[1:0] == 2'h0);
  assign divWrite    = wrAccept & (avlReq.address[7:2] == baud_gen_pkg::BAUD_DIV_IDX[5:0]);

  assign syncMode    = st_r.xmtStatus[baud_gen_pkg::XMT_SYNC_BIT];
  assign clockMaster = syncMode & st_r.xmtStatus[baud_gen_pkg::XMT_CLKSRC_BIT];
  assign tickActive  = ~syncMode | clockMaster;
  assign portEnable  = st_r.rcvStatus[baud_gen_pkg::RCV_ENABLE_BIT];
  assign rateTick    = st_r.rateTick;
  assign readdata    = st_r.rdData;

  assign baseTick = (st_r.prescale == baud_gen_pkg::PRESCALE_LAST)
                    && (st_r.timer == st_r.divisor);

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = busReq & ~st_r.ack;
    if (busReq && !st_r.ack && avlReq.read) begin
      st_nxt.rdData = (avlReq.address[1:0] == 2'h0)
                      ? read_mux({2'b00, avlReq.address[7:2]}, st_r) : 32'h0000_0000;
    end
    if (wrAccept) begin
      case ({2'b00, avlReq.address[7:2]})
        baud_gen_pkg::RCV_STATUS_IDX:
          st_nxt.rcvStatus = avlReq.writedata[7:0] & baud_gen_pkg::RCV_WRITE_MASK;
        baud_gen_pkg::XMT_STATUS_IDX:
          st_nxt.xmtStatus = avlReq.writedata[7:0] & baud_gen_pkg::XMT_WRITE_MASK;
        baud_gen_pkg::BAUD_DIV_IDX:
          st_nxt.divisor = avlReq.writedata[7:0];
        default: st_nxt.divisor = st_r.divisor;
      endcase
    end
    // Free-running timer at a quarter of the clock
    st_nxt.prescale = st_r.prescale + 2'h1;
    if (st_r.prescale == baud_gen_pkg::PRESCALE_LAST) begin
      st_nxt.timer = (st_r.timer == st_r.divisor) ? 8'h00 : st_r.timer + 8'h01;
    end
    if (baseTick) begin
      st_nxt.oversample = st_r.oversample + 4'h1;
    end
    st_nxt.rateTick = tickActive & baseTick
                      & (syncMode | (st_r.oversample == baud_gen_pkg::OVERSAMPLE_LAST));
    // New rate starts at once rather than after the old period ends
    if (divWrite) begin
      st_nxt.prescale   = 2'h0;
      st_nxt.timer      = 8'h00;
      st_nxt.oversample = 4'h0;
      st_nxt.rateTick   = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.ack        <= 1'b0;
      st_r.rdData     <= 32'h0000_0000;
      st_r.rcvStatus  <= baud_gen_pkg::RCV_STATUS_RST;
      st_r.xmtStatus  <= baud_gen_pkg::XMT_STATUS_RST;
      st_r.divisor    <= baud_gen_pkg::BAUD_DIV_RST;
      st_r.prescale   <= 2'h0;
      st_r.timer      <= 8'h00;
      st_r.oversample <= 4'h0;
      st_r.rateTick   <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Assertion helpers: cycles between output ticks
  logic [14:0] gapCnt_r;
  logic        armed_r;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gapCnt_r <= 15'h0000;
      armed_r  <= 1'b0;
    end else begin
      gapCnt_r <= (wrAccept || st_r.rateTick) ? 15'h0000 : gapCnt_r + 15'h0001;
      armed_r  <= wrAccept ? 1'b0 : (st_r.rateTick ? 1'b1 : armed_r);
    end
  end

  // ==========================================================
  // Assertions
  div_reset_a: assert property (@(posedge sys_clk)
    $past(sys_rst) |-> st_r.divisor == 8'h00)
    else $error("divisor not zero after reset");

  div_store_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    divWrite |=> st_r.divisor == $past(avlReq.writedata[7:0]))
    else $error("divisor write not stored");

  timer_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    divWrite |=> (st_r.timer == 8'h00 && st_r.prescale == 2'h0 && !st_r.rateTick))
    else $error("timer not cleared by divisor write");

  timer_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_r.timer <= st_r.divisor)
    else $error("timer beyond divisor");

  async_rate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.rateTick && armed_r && !syncMode)
      |-> gapCnt_r == 15'((st_r.divisor + 9'd1) * 64 - 1))
    else $error("asynchronous tick period wrong");

  sync_rate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.rateTick && armed_r && syncMode)
      |-> gapCnt_r == 15'((st_r.divisor + 9'd1) * 4 - 1))
    else $error("synchronous tick period wrong");

  slave_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (syncMode && !clockMaster && $past(syncMode) && !$past(clockMaster)) |-> !rateTick)
    else $error("tick in synchronous slave mode");

  master_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clockMaster == (st_r.xmtStatus[4] && st_r.xmtStatus[7]))
    else $error("clock source selection wrong");

  mode_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wrAccept && avlReq.address[7:2] == 6'h15) |=> syncMode == $past(avlReq.writedata[4]))
    else $error("mode select not taken");

  prescale_tick_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sys_rst == 1'b0 && syncMode && clockMaster && !divWrite && baseTick) |=> rateTick)
    else $error("base tick not passed out");

  bus_answer_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    busReq |-> ##[0:1] !waitrequest)
    else $error("bus answer late");

  // ==========================================================
  // Bus assertions
  wait_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (busReq && !st_r.ack) |-> waitrequest)
    else $error("first request cycle not stalled");

  ack_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_r.ack |=> !st_r.ack)
    else $error("acknowledge longer than one cycle");

  ack_req_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.ack && !$past(sys_rst)) |-> $past(busReq))
    else $error("acknowledge without request");

  rd_upper_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (busReq && !waitrequest) |-> readdata[31:8] == 24'h000000)
    else $error("read data upper bits set");

  rd_shift_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (accept && avlReq.read && avlReq.address == 8'h54) |-> readdata[1])
    else $error("shift empty flag not reported");

  rd_div_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (accept && avlReq.read && avlReq.address == 8'h5c) |-> readdata[7:0] == st_r.divisor)
    else $error("divisor read back wrong");

  rd_unmapped_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (accept && avlReq.read && avlReq.address[1:0] != 2'h0) |-> readdata == 32'h0000_0000)
    else $error("misaligned read not zero");

  rd_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(busReq && !st_r.ack && avlReq.read) |=> $stable(readdata))
    else $error("read data changed without read");

  // ==========================================================
  // Register assertions
  div_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!$past(divWrite) && !$past(sys_rst)) |-> $stable(st_r.divisor))
    else $error("divisor changed without write");

  mode_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!$past(wrAccept) && !$past(sys_rst)) |-> $stable(st_r.xmtStatus))
    else $error("transmit status changed without write");

  rcv_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!$past(wrAccept) && !$past(sys_rst)) |-> $stable(st_r.rcvStatus))
    else $error("receive status changed without write");

  port_en_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wrAccept && avlReq.address == 8'h4c) |=> portEnable == $past(avlReq.writedata[7]))
    else $error("port enable not taken");

  rcv_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_r.rcvStatus[3:0] == 4'h0)
    else $error("receive reserved bits set");

  xmt_res_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_r.xmtStatus[3:1] == 3'h0)
    else $error("transmit reserved bits set");

  // ==========================================================
  // Timer assertions
  prescale_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!$past(divWrite) && !$past(sys_rst))
      |-> st_r.prescale == 2'($past(st_r.prescale) + 2'h1))
    else $error("prescaler did not advance");

  timer_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.prescale != baud_gen_pkg::PRESCALE_LAST && !divWrite) |=> $stable(st_r.timer))
    else $error("timer moved between prescaler ends");

  timer_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (baseTick && !divWrite) |=> st_r.timer == 8'h00)
    else $error("timer did not wrap at divisor");

  timer_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_r.prescale == baud_gen_pkg::PRESCALE_LAST && st_r.timer != st_r.divisor && !divWrite)
      |=> st_r.timer == 8'($past(st_r.timer) + 8'h01))
    else $error("timer did not step");

  over_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!baseTick && !divWrite) |=> $stable(st_r.oversample))
    else $error("oversample moved without base tick");

  over_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    divWrite |=> st_r.oversample == 4'h0)
    else $error("oversample not cleared by divisor write");

  // ==========================================================
  // Tick assertions
  tick_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rateTick |=> !rateTick)
    else $error("tick longer than one cycle");

  tick_base_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rateTick |-> $past(baseTick))
    else $error("tick without base tick");

  async_sixteen_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rateTick && !$past(syncMode)) |-> $past(st_r.oversample) == baud_gen_pkg::OVERSAMPLE_LAST)
    else $error("asynchronous tick not on sixteenth");

  tick_active_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rateTick |-> $past(tickActive))
    else $error("tick while generator unused");

  tick_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    divWrite |=> !rateTick [*4])
    else $error("stale tick after divisor write");

  tick_after_rst_a: assert property (@(posedge sys_clk)
    $past(sys_rst) |-> !rateTick)
    else $error("tick right after reset");

endmodule : serial_baud_rate_generator

// file: verification/serial_port_model.sv
`timescale 1ns/1ns
// ==========================================================
// Serial port side: consumes the rate tick, keeps its timing
module serial_port_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Rate from generator
  input  wire logic        rateTick,
  // Observed tick timing
  output logic      [15:0] tickCount,
  output logic      [15:0] lastPeriod
);
  logic [15:0] gap_r;
  // Shifter would advance one bit per tick; only the spacing matters here
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCount  <= 16'h0000;
      lastPeriod <= 16'h0000;
      gap_r      <= 16'h0000;
    end else if (rateTick) begin
      tickCount  <= tickCount + 16'h0001;
      lastPeriod <= gap_r + 16'h0001;
      gap_r      <= 16'h0000;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end
endmodule : serial_port_model

// file: verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                      sys_clk = 1'b0;
  logic                      sys_rst;
  baud_gen_pkg::avl_req_type avlReq;
  logic [31:0]               readdata;
  logic                      waitrequest;
  logic                      rateTick;
  logic                      syncMode;
  logic                      clockMaster;
  logic                      portEnable;
  logic [15:0]               tickCount;
  logic [15:0]               lastPeriod;
  int                        mismatches;
  int                        total_checks;
  int                        k;
  logic [15:0]               c;

  always #5 sys_clk = ~sys_clk;

  serial_baud_rate_generator dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avlReq(avlReq),
    .readdata(readdata), .waitrequest(waitrequest), .rateTick(rateTick),
    .syncMode(syncMode), .clockMaster(clockMaster), .portEnable(portEnable));
  serial_port_model port (.sys_clk(sys_clk), .sys_rst(sys_rst), .rateTick(rateTick),
    .tickCount(tickCount), .lastPeriod(lastPeriod));

  // ==========================================================
  // Checking and verdict
  task checkVal(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : checkVal

  task results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // ==========================================================
  // Avalon accesses: hold until waitrequest low, then a quiet edge
  task busOp(input logic wr, input logic [7:0] addr, input logic [7:0] data,
             output logic [31:0] rd);
    int n;
    avlReq.read      <= !wr;
    avlReq.write     <= wr;
    avlReq.address   <= addr;
    avlReq.writedata <= {24'h000000, data};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) mismatches++;
    rd = readdata;
    avlReq.read  <= 1'b0;
    avlReq.write <= 1'b0;
    @(posedge sys_clk);
  endtask : busOp

  task wrReg(input logic [7:0] addr, input logic [7:0] data);
    logic [31:0] rd;
    busOp(1'b1, addr, data, rd);
  endtask : wrReg

  task expectReg(input string name, input logic [7:0] addr, input logic [7:0] exp);
    logic [31:0] rd;
    busOp(1'b0, addr, 8'h00, rd);
    checkVal(name, {24'h000000, exp}, rd);
  endtask : expectReg

  // Bounded wait for a number of ticks; the last spacing is then a full period
  task waitTicks(input int n, input logic [15:0] period);
    c = tickCount;
    k = 0;
    while (tickCount !== c + n && k < 5000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 5000) mismatches++;
    checkVal("tick period", {16'h0000, period}, {16'h0000, lastPeriod});
  endtask : waitTicks

  // ==========================================================
  // Main sequence
  initial begin
    avlReq = '0;
    avlReq.byteenable = 4'h1;
    sys_rst = 1'b1;
    mismatches = 0;
    total_checks = 0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    expectReg("divisor reset", 8'h5c, 8'h00);
    expectReg("xmt reset", 8'h54, 8'h02);
    wrReg(8'h70, 8'h55);
    expectReg("unmapped", 8'h70, 8'h00);
    wrReg(8'h5c, 8'hff);
    expectReg("divisor max", 8'h5c, 8'hff);
    wrReg(8'h4c, 8'h80);
    expectReg("rcv status", 8'h4c, 8'h80);
    wrReg(8'h54, 8'h90);
    expectReg("xmt status", 8'h54, 8'h92);
    checkVal("master flags", 32'h7, {29'h0, portEnable, syncMode, clockMaster});
    waitTicks(2, 16'd1024);
    repeat (300) @(posedge sys_clk);
    // Old period has ~700 cycles left; a cleared timer ticks within 10
    c = tickCount;
    wrReg(8'h5c, 8'h01);
    k = 0;
    while (tickCount === c && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    checkVal("restart delay", 32'h1, {31'h0, k <= 10});
    waitTicks(2, 16'd8);
    wrReg(8'h5c, 8'h00);
    waitTicks(2, 16'd4);
    wrReg(8'h54, 8'h10);
    checkVal("slave flags", 32'h6, {29'h0, portEnable, syncMode, clockMaster});
    repeat (2) @(posedge sys_clk);
    c = tickCount;
    repeat (100) @(posedge sys_clk);
    checkVal("slave ticks", {16'h0000, c}, {16'h0000, tickCount});
    wrReg(8'h54, 8'h00);
    wrReg(8'h5c, 8'h03);
    waitTicks(2, 16'd256);
    wrReg(8'h5c, 8'h00);
    waitTicks(2, 16'd64);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    expectReg("divisor rereset", 8'h5c, 8'h00);
    expectReg("timer rereset", 8'h60, 8'h00);
    results;
  end

  // Whole run is under 8000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    results;
  end
endmodule : tb_top
